// ---- shared/bio_defines.vh ----
/*
  Constants for the bytewise I/O port: register offsets, reset values,
  polarity values and the unmapped read value.
  Assumes inclusion by bare name from the design file.
*/
// Contract
// - dir0 opt0 data0: input with pull-up
// - dir0 opt0 data1: input, no pull-up
// - dir0 opt1 data0: pull-up, interrupt source
// - dir0 opt1 data1: analog input to converter
// - dir1 opt0: open-drain output from latch
// - dir1 opt1: push-pull output from latch
// - three 8-bit registers, bit n per line
// - reset clears all registers
// - data read of input returns pin
// - data write updates every latch bit
// - each input individually connectable to interrupt
// - pin requests merged, edge, selectable polarity
`ifndef BIO_DEFINES_VH
`define BIO_DEFINES_VH
// Register offsets within the port
`define BIO_OFS_DATA      2'h0
`define BIO_OFS_DIRECTION 2'h1
`define BIO_OFS_OPTION    2'h2
// Reset values
`define BIO_RST_DATA      8'h00
`define BIO_RST_DIRECTION 8'h00
`define BIO_RST_OPTION    8'h00
// Edge polarity values
`define BIO_POL_FALLING   1'b0
`define BIO_POL_RISING    1'b1
// Read value of the unmapped offset
`define BIO_UNMAPPED_READ 8'h00
// Reset values of the registered outputs and edge history
`define BIO_RST_RDATA     8'h00
`define BIO_RST_PAD       8'h00
`define BIO_RST_EDGE_PREV 8'hFF
`define BIO_RST_IRQ       1'b0
`endif

// ---- hw/bio_port.v ----
/*
  Bytewise general-purpose I/O port: data, direction and option registers,
  per-line pad control, analog select, merged edge interrupt request.
  Assumes a synchronous single-cycle register port on the core clock and
  pad inputs already synchronous to the clock.
*/
`timescale 1ns/100ps
`include "bio_defines.vh"

module bio_port
(
  input  wire       clock,
  input  wire       rst,
  input  wire       reg_sel,
  input  wire       reg_wr,
  input  wire [1:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire [7:0] pin_in,
  output reg  [7:0] pin_out,
  output reg  [7:0] pin_oe,
  output reg  [7:0] pin_pullup_en,
  output reg  [7:0] analog_sel,
  input  wire       edge_polarity_select,
  output reg        port_irq_req
);

  ////////////////////////////////////////////////////////////////////
  // Line mode codes, one per row of the option table
  localparam [2:0] MODE_IN_PULL   = 3'h0; // Input, pull-up, no interrupt
  localparam [2:0] MODE_IN_FLOAT  = 3'h1; // Input, high impedance
  localparam [2:0] MODE_IN_IRQ    = 3'h2; // Input, pull-up, interrupt
  localparam [2:0] MODE_IN_ANALOG = 3'h3; // Input to converter mux
  localparam [2:0] MODE_OUT_OD    = 3'h4; // Output, pulls low only
  localparam [2:0] MODE_OUT_PP    = 3'h5; // Output, drives both levels

  ////////////////////////////////////////////////////////////////////
  // Control registers
  reg  [7:0] line_data_bit_r;
  reg  [7:0] direction_r;
  reg  [7:0] option_r;

  // Edge detect history
  reg  [7:0] irq_line_prev_r;

  // Next values of the registered outputs
  reg  [7:0] rdata_nxt;
  reg  [7:0] pin_out_nxt;
  reg  [7:0] pin_oe_nxt;
  reg  [7:0] pullup_nxt;
  reg  [7:0] analog_nxt;
  wire       irq_req_nxt;

  // Decode helpers
  reg  [7:0] irq_en;
  reg  [2:0] mode_cur;
  wire       wr_data;
  wire       wr_direction;
  wire       wr_option;
  wire       rd_strobe;
  wire       pol_falling;
  wire [7:0] irq_level;
  wire [7:0] irq_edge;
  integer    n;

  ////////////////////////////////////////////////////////////////////
  // Write hit on one register offset
  function write_hit;
    input       sel;
    input       wr;
    input [1:0] addr;
    input [1:0] ofs;
    begin
      write_hit = sel && wr && (addr == ofs);
    end
  endfunction

  // Mode of one line from its own three control bits
  function [2:0] line_mode;
    input dir_bit;
    input opt_bit;
    input dat_bit;
    begin
      if (dir_bit)
      begin
        if (opt_bit)
          line_mode = MODE_OUT_PP;
        else
          line_mode = MODE_OUT_OD;
      end
      else if (opt_bit)
      begin
        if (dat_bit)
          line_mode = MODE_IN_ANALOG;
        else
          line_mode = MODE_IN_IRQ;
      end
      else
      begin
        if (dat_bit)
          line_mode = MODE_IN_FLOAT;
        else
          line_mode = MODE_IN_PULL;
      end
    end
  endfunction

  // Pad controls of one line: {interrupt, analog, pull-up, enable, value}
  function [4:0] pad_bits;
    input [2:0] mode;
    input       dat_bit;
    begin
      case (mode)
        MODE_IN_PULL:   pad_bits = 5'h04;
        MODE_IN_FLOAT:  pad_bits = 5'h00;
        MODE_IN_IRQ:    pad_bits = 5'h14;
        MODE_IN_ANALOG: pad_bits = 5'h08;
        MODE_OUT_OD:    pad_bits = {3'h0, ~dat_bit, dat_bit};
        MODE_OUT_PP:    pad_bits = {3'h0, 1'b1, dat_bit};
        default:        pad_bits = 5'h00;
      endcase
    end
  endfunction

  // Active level of each pin for the selected edge
  function [7:0] active_level;
    input [7:0] pins;
    input       falling;
    begin
      active_level = pins ^ {8{falling}};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Access decode
  assign wr_data      = write_hit(reg_sel, reg_wr, reg_addr, `BIO_OFS_DATA);
  assign wr_direction = write_hit(reg_sel, reg_wr, reg_addr, `BIO_OFS_DIRECTION);
  assign wr_option    = write_hit(reg_sel, reg_wr, reg_addr, `BIO_OFS_OPTION);
  assign rd_strobe    = reg_sel && !reg_wr;

  ////////////////////////////////////////////////////////////////////
  // Data latch, always written as a whole byte
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      line_data_bit_r <= `BIO_RST_DATA;
    end
    else if (wr_data)
    begin
      line_data_bit_r <= reg_wdata;
    end
  end

  // Direction register
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      direction_r <= `BIO_RST_DIRECTION;
    end
    else if (wr_direction)
    begin
      direction_r <= reg_wdata;
    end
  end

  // Option register
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      option_r <= `BIO_RST_OPTION;
    end
    else if (wr_option)
    begin
      option_r <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-line decode; line n sees only bit n of each register
  always @*
  begin
    mode_cur    = MODE_IN_PULL;
    irq_en      = 8'h00;
    analog_nxt  = 8'h00;
    pullup_nxt  = 8'h00;
    pin_oe_nxt  = 8'h00;
    pin_out_nxt = 8'h00;
    for (n = 0; n < 8; n = n + 1)
    begin
      mode_cur = line_mode(direction_r[n], option_r[n], line_data_bit_r[n]);
      {irq_en[n], analog_nxt[n], pullup_nxt[n], pin_oe_nxt[n], pin_out_nxt[n]} =
        pad_bits(mode_cur, line_data_bit_r[n]);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux: pins for inputs, latch for outputs
  always @*
  begin
    case (reg_addr)
      `BIO_OFS_DATA:
        rdata_nxt = (pin_in & ~direction_r) | (line_data_bit_r & direction_r);
      `BIO_OFS_DIRECTION:
        rdata_nxt = direction_r;
      `BIO_OFS_OPTION:
        rdata_nxt = option_r;
      default:
        rdata_nxt = `BIO_UNMAPPED_READ;
    endcase
  end

  // Read data registered, held until the next read
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= `BIO_RST_RDATA;
    end
    else if (rd_strobe)
    begin
      reg_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pad value and enable; open-drain only enables on a low latch
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_out <= `BIO_RST_PAD;
      pin_oe  <= `BIO_RST_PAD;
    end
    else
    begin
      pin_out <= pin_out_nxt;
      pin_oe  <= pin_oe_nxt;
    end
  end

  // Pull-up enables
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_pullup_en <= `BIO_RST_PAD;
    end
    else
    begin
      pin_pullup_en <= pullup_nxt;
    end
  end

  // Analog mux selects
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      analog_sel <= `BIO_RST_PAD;
    end
    else
    begin
      analog_sel <= analog_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Merged edge detect; a line just enabled starts as already active,
  // so enabling it on its active level raises no request
  assign pol_falling = (edge_polarity_select == `BIO_POL_FALLING);
  assign irq_level   = active_level(pin_in, pol_falling);
  assign irq_edge    = irq_en & irq_level & ~irq_line_prev_r;
  assign irq_req_nxt = |irq_edge;

  // Edge history; disabled lines park at the active level
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irq_line_prev_r <= `BIO_RST_EDGE_PREV;
    end
    else
    begin
      irq_line_prev_r <= irq_level | ~irq_en;
    end
  end

  // One-cycle request pulse, all lines merged
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      port_irq_req <= `BIO_RST_IRQ;
    end
    else
    begin
      port_irq_req <= irq_req_nxt;
    end
  end

endmodule

// ---- sim/bio_port_asserts.sv ----
/* Checker for bio_port: pad modes, reads, interrupt cause.
   Assumes a bind to bio_port and one clock. */
`timescale 1ns/100ps
module bio_port_asserts
(
  input wire       clock,
  input wire       rst,
  input wire       reg_sel,
  input wire       reg_wr,
  input wire [1:0] reg_addr,
  input wire [7:0] reg_rdata,
  input wire [7:0] pin_in,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] pin_pullup_en,
  input wire [7:0] analog_sel,
  input wire       port_irq_req
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Mode exclusion, reset state, reads, interrupt cause
  chk_pull_off_out: assert property ((pin_pullup_en & pin_oe) == 8'h00) else $error("pull");
  chk_analog_alone: assert property ((analog_sel & (pin_pullup_en | pin_oe)) == 8'h00)
    else $error("analog");
  chk_reset_pull: assert property ($fell(rst) |=> pin_pullup_en == 8'hFF) else $error("rst");
  chk_unmapped_zero: assert property (reg_sel && !reg_wr && reg_addr == 2'h3
    |=> reg_rdata == 8'h00) else $error("unmapped");
  chk_input_read: assert property (reg_sel && !reg_wr && reg_addr == 2'h0
    && !$past(reg_sel && reg_wr)
    |=> ((reg_rdata ^ $past(pin_in)) & $past(pin_pullup_en)) == 8'h00) else $error("in");
  chk_output_read: assert property (reg_sel && !reg_wr && reg_addr == 2'h0
    && !$past(reg_sel && reg_wr)
    |=> ((reg_rdata ^ $past(pin_out)) & $past(pin_oe)) == 8'h00) else $error("out");
  chk_rdata_hold: assert property (!(reg_sel && !reg_wr) |=> $stable(reg_rdata))
    else $error("hold");
  chk_irq_cause: assert property (port_irq_req |-> $past(pin_in) != $past(pin_in, 2))
    else $error("irq");
endmodule

// ---- sim/bio_pad_model.sv ----
/* Pad model: resolves each line level.
   Assumes the outside drives every line the port leaves undriven. */
`timescale 1ns/100ps
module bio_pad_model
(
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe,
  input  wire [7:0] ext,
  output wire [7:0] pin_in
);
  // Driven lines carry the port value
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// ---- sim/tb.sv ----
/* Bench for bio_port with the pad model.
   Assumes registered outputs and one-cycle accesses. */
`timescale 1ns/100ps
`define CK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t bad value", $time); end end
bind bio_port bio_port_asserts chk (.clock(clock), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pullup_en(pin_pullup_en), .analog_sel(analog_sel), .port_irq_req(port_irq_req));
module tb;
  reg       clock = 1'b0, rst = 1'b1, reg_sel = 1'b0, reg_wr = 1'b0, seen;
  reg       edge_polarity_select = 1'b0;
  reg [1:0] reg_addr = 2'h0;
  reg [7:0] reg_wdata = 8'h00, ext = 8'h3C;
  wire [7:0] reg_rdata, pin_in, pin_out, pin_oe, pin_pullup_en, analog_sel;
  wire       port_irq_req;
  int        bad_count = 0, samples_checked = 0;
  bio_port dut (.clock(clock), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .analog_sel(analog_sel),
    .edge_polarity_select(edge_polarity_select), .port_irq_req(port_irq_req));
  bio_pad_model pad (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  // One register access, result settled at return
  task acc(input [1:0] a, input w, input [7:0] d);
    @(posedge clock);
    reg_sel <= 1'b1; reg_wr <= w; reg_addr <= a; reg_wdata <= d;
    @(posedge clock);
    reg_sel <= 1'b0;
    @(negedge clock);
  endtask
  // Move the lines and look for a request pulse
  task irq_try(input [7:0] v, input exp_pulse);
    @(posedge clock);
    ext <= v;
    seen = 1'b0;
    repeat (3) @(negedge clock) seen = seen | port_irq_req;
    `CK(seen, exp_pulse)
  endtask
  task complete_run;
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Clock and hang guard
  initial forever #2 clock = ~clock;
  initial begin #20000; bad_count++; complete_run; end
  // Reset state, modes, reads, interrupts
  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(negedge clock);
    `CK(pin_pullup_en, 8'hFF)
    acc(2'h0, 1'b0, 8'h00);
    `CK(reg_rdata, 8'h3C)
    for (int i = 1; i < 4; i++) begin acc(i[1:0], 1'b0, 8'h00); `CK(reg_rdata, 8'h00) end
    acc(2'h1, 1'b1, 8'hF0);
    acc(2'h0, 1'b1, 8'hAA);
    acc(2'h2, 1'b1, 8'hCC);
    @(negedge clock);
    `CK({pin_oe, pin_out}, 16'hD0A0)
    `CK({pin_pullup_en, analog_sel}, 16'h0508)
    acc(2'h0, 1'b0, 8'h00);
    `CK(reg_rdata, 8'hAC)
    acc(2'h2, 1'b0, 8'h00);
    `CK(reg_rdata, 8'hCC)
    irq_try(8'h38, 1'b1);
    irq_try(8'h39, 1'b0);
    irq_try(8'h38, 1'b0);
    @(posedge clock);
    edge_polarity_select <= 1'b1;
    irq_try(8'h3C, 1'b1);
    // Second reset in mid-run clears the data, direction and option registers
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(negedge clock);
    `CK({pin_oe, pin_out, pin_pullup_en, analog_sel}, 32'h0000FF00)
    acc(2'h2, 1'b0, 8'h00);
    `CK(reg_rdata, 8'h00)
    complete_run;
  end
endmodule
